// >>> src/msts_pkg.sv
// Constants and types for the memory self-test sequencer
// Functional notes
// - Test mode overrides all; RAMs gated otherwise
// - 56-bit instruction: 18 controller, 38 dispatch
// - Shift loads bits, forwards stream on bit 3
// - Log shift after fail; controller stalls meanwhile in bitmap mode only
// - Result 5:2 per CPU: log, instruction, expiry
// - Result 1 any fail, result 0 finished
// - Decode instruction, FSM steps the algorithm
// - Generate addresses, compare through read pipeline
// - Replaceable scrambler maps logical to physical
// - Bus bits: stall, forced seed, bitmap mode
// - Bus bits: row fast, direction, step, restart
// - Read mode, registered write enable, no compare
// - Checkerboard, sacrifice, seed invert or load
// - Return bus: expiry or shift-out, stall, fail
// - Drive data, address, bit/chip/write enables
// - Read data slices per CPU, CPU order
// - Chip enables 17..9: snoop, data, tag, dirty
// - Chip enables 8..0: instr, branch, translation
// - Every location written and read, four CPUs
package msts_pkg;
    localparam int CTRL_W = 18;
    localparam int DISP_W = 38;
    localparam int NCPU = 4;
    localparam int DATA_W = 64;
    localparam int ADDR_W = 11;
    localparam int X_W = 4;
    localparam int Y_W = 7;
    localparam int CE_W = 18;
    localparam int BE_W = 24;
    localparam int RDATA_W = 256;
    localparam int LOG_W = 79;
    localparam int TX_W = 12;
    localparam int RX_W = 6;
    localparam int RES_W = 6;
    localparam int RD_PIPE = 2;
    localparam int WAIT_W = 4;
    localparam int TX_STALL = 11;
    localparam int TX_SEED = 10;
    localparam int TX_BITMAP = 9;
    localparam int TX_ROWF = 8;
    localparam int TX_DOWN = 7;
    localparam int TX_READ = 6;
    localparam int TX_WRITE = 5;
    localparam int TX_CKBD = 4;
    localparam int TX_INV = 3;
    localparam int TX_SACR = 2;
    localparam int TX_STEP = 1;
    localparam int TX_ARST = 0;
    localparam int RX_EXP = 2;
    localparam int RX_STALL = 1;
    localparam int RX_FAIL = 0;
    localparam int C_MARCH = 12;
    localparam int C_CKBD = 13;
    localparam int C_DOWN = 14;
    localparam int C_ROWF = 15;
    localparam int C_BITMAP = 6;
    localparam int C_STOP = 7;
    localparam int C_GONOGO = 8;
    localparam int C_WLAT = 3;
    localparam int C_RLAT = 0;
    localparam int LAT_W = 3;
    localparam int D_CPU = 34;
    localparam int D_MAXX = 30;
    localparam int D_MAXY = 26;
    localparam int D_SEED = 22;
    localparam int D_CE = 4;
    localparam int SEED_W = 4;
    localparam logic [SEED_W-1:0] GONOGO_SEED = 4'h5;
    localparam logic [2:0] Y_PAD = 3'h7;
    localparam logic [BE_W-1:0] BE_ALL = 24'hffffff;
    localparam logic [DATA_W-1:0] CKBD_MASK = 64'h5555555555555555;
    typedef enum logic [2:0] {
        MSTS_IDLE, MSTS_START, MSTS_ACCESS, MSTS_DRAIN, MSTS_LOG, MSTS_DONE
    } msts_state_e;
endpackage

// >>> src/msts_dispatch.sv
// Dispatch unit: address generation, RAM drive, compare and fail logs
`timescale 1ns/1ps
module msts_dispatch
    import msts_pkg::*;
(
    input wire logic clock, // Core clock
    input wire logic rstn, // Synchronised reset, active low
    input wire logic testMode, // Self-test mode active
    input wire logic shiftEn, // Instruction load enable
    input wire logic logShift, // Fail log shift-out enable
    input wire logic [TX_W-1:0] txBus, // Commands from controller
    input wire logic [RDATA_W-1:0] ramRdataAll, // Read data, all CPUs
    output logic [RX_W-1:0] rxBus, // Status to controller
    output logic [NCPU-1:0] logBits, // Serial fail log bits
    output logic [DATA_W-1:0] ramWdata, // RAM write data
    output logic [ADDR_W-1:0] ramAddr, // RAM address
    output logic [BE_W-1:0] ramBitEnable, // RAM bit enables
    output logic [CE_W-1:0] ramChipEnable, // RAM chip enables
    output logic ramWriteEnable // Global write enable
);
    logic [DISP_W-1:0] instr;
    logic [SEED_W-1:0] seed;
    logic [X_W-1:0] xCnt, xHi, xEnd, xStart;
    logic [Y_W-1:0] yCnt, yHi, yEnd, yStart;
    logic down, expired, access, enter, stallPulse;
    logic pipeV [RD_PIPE];
    logic [DATA_W-1:0] pipeE [RD_PIPE];
    logic [ADDR_W-1:0] pipeA [RD_PIPE];
    logic [DATA_W-1:0] diff [NCPU];
    logic [NCPU-1:0] cmpFail, failSticky;
    logic [LOG_W-1:0] logReg [NCPU];

    // Replace to suit the RAM's physical layout
    function automatic logic [ADDR_W-1:0] scramble(logic [ADDR_W-1:0] a);
        return {a[ADDR_W-1:X_W], a[X_W-1:0] ^ (a[X_W-1:0] >> 1)};
    endfunction
    function automatic logic [Y_W-1:0] bump(logic [Y_W-1:0] v, logic dn);
        return dn ? v - 7'h1 : v + 7'h1;
    endfunction
    function automatic logic [DATA_W-1:0] pattern(logic [ADDR_W-1:0] a);
        logic [DATA_W-1:0] w;
        w = {(DATA_W / SEED_W){seed ^ {SEED_W{txBus[TX_INV]}}}};
        if (txBus[TX_CKBD] && (a[0] ^ a[X_W])) w = w ^ CKBD_MASK;
        return w;
    endfunction

    assign down = txBus[TX_DOWN];
    assign xHi = instr[D_MAXX +: X_W];
    assign yHi = {instr[D_MAXY +: SEED_W], Y_PAD};
    assign xEnd = down ? '0 : xHi;
    assign yEnd = down ? '0 : yHi;
    assign xStart = down ? xHi : '0;
    assign yStart = down ? yHi : '0;
    assign expired = (xCnt == xEnd) && (yCnt == yEnd);
    assign access = testMode && !txBus[TX_STALL] && (txBus[TX_READ] || txBus[TX_WRITE]);
    // No compare in write mode or on a sacrificial read
    assign enter = access && txBus[TX_READ] && !txBus[TX_WRITE] && !txBus[TX_SACR];
    assign rxBus = {shiftEn ? {NCPU{instr[0]}} : {NCPU{expired}}, stallPulse, |failSticky};

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) instr <= '0;
        else if (shiftEn) instr <= {txBus[TX_INV], instr[DISP_W-1:1]};
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            xCnt <= '0;
            yCnt <= '0;
            seed <= '0;
        end else if (txBus[TX_ARST]) begin
            xCnt <= xStart;
            yCnt <= yStart;
            seed <= txBus[TX_SEED] ? GONOGO_SEED : instr[D_SEED +: SEED_W];
        end else if (txBus[TX_STEP] && !txBus[TX_STALL]) begin
            if (txBus[TX_ROWF]) begin
                yCnt <= (yCnt == yEnd) ? yStart : bump(yCnt, down);
                if (yCnt == yEnd) xCnt <= X_W'(bump({3'h0, xCnt}, down));
            end else begin
                xCnt <= (xCnt == xEnd) ? xStart : X_W'(bump({3'h0, xCnt}, down));
                if (xCnt == xEnd) yCnt <= bump(yCnt, down);
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ramAddr <= '0;
            ramWdata <= '0;
            ramChipEnable <= '0;
            ramBitEnable <= '0;
            ramWriteEnable <= 1'b0;
        end else begin
            ramChipEnable <= access ? instr[D_CE +: CE_W] : '0;
            ramBitEnable <= access ? BE_ALL : '0;
            ramWriteEnable <= access && txBus[TX_WRITE];
            if (access) ramAddr <= scramble({yCnt, xCnt});
            if (access) ramWdata <= pattern({yCnt, xCnt});
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            for (int s = 0; s < RD_PIPE; s++) begin
                pipeV[s] <= 1'b0;
                pipeE[s] <= '0;
                pipeA[s] <= '0;
            end
        end else begin
            pipeV[0] <= enter;
            pipeE[0] <= pattern({yCnt, xCnt});
            pipeA[0] <= scramble({yCnt, xCnt});
            for (int s = 1; s < RD_PIPE; s++) begin
                pipeV[s] <= pipeV[s-1];
                pipeE[s] <= pipeE[s-1];
                pipeA[s] <= pipeA[s-1];
            end
        end
    end

    always_comb begin
        for (int c = 0; c < NCPU; c++) begin
            diff[c] = ramRdataAll[c*DATA_W +: DATA_W] ^ pipeE[RD_PIPE-1];
            cmpFail[c] = pipeV[RD_PIPE-1] && instr[D_CPU+c] && (|diff[c]);
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            failSticky <= '0;
            stallPulse <= 1'b0;
            logBits <= '0;
            for (int c = 0; c < NCPU; c++) logReg[c] <= '0;
        end else begin
            stallPulse <= txBus[TX_BITMAP] && (|cmpFail) && !logShift;
            for (int c = 0; c < NCPU; c++) begin
                logBits[c] <= logReg[c][0];
                // A fail in the same cycle as a load clear must not be lost
                if (cmpFail[c]) failSticky[c] <= 1'b1;
                else if (shiftEn) failSticky[c] <= 1'b0;
                if (logShift) logReg[c] <= logReg[c] >> 1;
                else if (cmpFail[c] && (txBus[TX_BITMAP] || !failSticky[c]))
                    logReg[c] <= {pipeA[RD_PIPE-1], diff[c], seed};
            end
        end
    end

    ce_gate_a: assert property (@(posedge clock) disable iff (!rstn)
        !testMode |=> ramChipEnable == '0) else $error("chip enable outside test mode");
    we_reg_a: assert property (@(posedge clock) disable iff (!rstn)
        access && txBus[TX_WRITE] |=> ramWriteEnable) else $error("write enable not registered");
    wr_nocmp_a: assert property (@(posedge clock) disable iff (!rstn)
        txBus[TX_WRITE] |-> ##2 !pipeV[RD_PIPE-1]) else $error("compare in write mode");
endmodule // msts_dispatch

// >>> src/msts_sequencer.sv
// Memory self-test sequencer top: tester pins and controller state machine
`timescale 1ns/1ps
module msts_sequencer
    import msts_pkg::*;
(
    input wire logic clock, // Core clock, 10 MHz
    input wire logic resetn, // Asynchronous reset, active low
    input wire logic testModeOn, // Self-test mode select pin
    input wire logic instrShiftEn, // Instruction load enable pin
    input wire logic logShiftEn, // Fail log shift enable pin
    input wire logic serialInstrIn, // Serial instruction data pin
    input wire logic runEn, // Run enable pin
    input wire logic [RDATA_W-1:0] ramRdataAll, // RAM read data, all CPUs
    output logic [RES_W-1:0] resultBus, // Results and status
    output logic [DATA_W-1:0] ramWdata, // RAM write data
    output logic [ADDR_W-1:0] ramAddr, // RAM address
    output logic [BE_W-1:0] ramBitEnable, // RAM bit enables
    output logic [CE_W-1:0] ramChipEnable, // RAM chip enables
    output logic ramWriteEnable // RAM global write enable
);
    ////////////////////////////////////////////////////////////////////
    // Declarations
    logic [1:0] rstPipe;
    logic rstn;
    logic [4:0] syncA;
    logic [4:0] syncB;
    logic testMode;
    logic instrShift;
    logic logShift;
    logic serialIn;
    logic runReq;
    logic [CTRL_W-1:0] ctrlReg;
    msts_state_e state;
    logic [1:0] phase;
    logic [WAIT_W-1:0] waitCnt;
    logic seenLog;
    logic fromDrain;
    logic firstAcc;
    logic lastPhase;
    logic acc;
    logic sacr;
    logic [TX_W-1:0] txBus;
    logic [RX_W-1:0] rxBus;
    logic [NCPU-1:0] logBits;
    logic [LAT_W-1:0] wlat;
    logic [LAT_W-1:0] rlat;

    // Cycles to let an access settle through the RAM and compare pipe
    function automatic logic [WAIT_W-1:0] drainCycles(logic [LAT_W-1:0] lat);
        return {1'b0, lat} + WAIT_W'(RD_PIPE);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Reset release
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rstPipe <= 2'h0;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end

    assign rstn = rstPipe[1];

    ////////////////////////////////////////////////////////////////////
    // Tester pin synchronisers
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            syncA <= 5'h0;
            syncB <= 5'h0;
        end else begin
            syncA <= {runEn, serialInstrIn, logShiftEn, instrShiftEn, testModeOn};
            syncB <= syncA;
        end
    end

    assign testMode = syncB[0];
    assign instrShift = syncB[1];
    assign logShift = syncB[2];
    assign serialIn = syncB[3];
    assign runReq = syncB[4];

    ////////////////////////////////////////////////////////////////////
    // Controller instruction bits
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctrlReg <= '0;
        end else if (instrShift && state == MSTS_IDLE) begin
            // Low bit leaves toward the dispatch unit
            ctrlReg <= {serialIn, ctrlReg[CTRL_W-1:1]};
        end
    end

    assign wlat = ctrlReg[C_WLAT +: LAT_W];
    assign rlat = ctrlReg[C_RLAT +: LAT_W];
    assign lastPhase = ctrlReg[C_MARCH] ? (phase == 2'h3) : (phase == 2'h1);
    assign acc = (state == MSTS_ACCESS);
    assign sacr = acc && phase[0] && firstAcc;

    ////////////////////////////////////////////////////////////////////
    // Algorithm state machine
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state <= MSTS_IDLE;
            phase <= 2'h0;
            waitCnt <= '0;
            seenLog <= 1'b0;
            fromDrain <= 1'b0;
        end else if (!testMode) begin
            state <= MSTS_IDLE;
            phase <= 2'h0;
        end else begin
            unique case (state)
                MSTS_IDLE: begin
                    if (runReq && !instrShift) begin
                        state <= MSTS_START;
                        phase <= 2'h0;
                    end
                end
                MSTS_START: begin
                    state <= MSTS_ACCESS;
                end
                MSTS_ACCESS: begin
                    if (!runReq) begin
                        state <= MSTS_IDLE;
                    end else if (rxBus[RX_FAIL] && ctrlReg[C_STOP]) begin
                        state <= MSTS_DONE;
                    end else if (rxBus[RX_STALL]) begin
                        state <= MSTS_LOG;
                        seenLog <= 1'b0;
                        fromDrain <= 1'b0;
                    end else if (rxBus[RX_EXP] && !sacr) begin
                        state <= MSTS_DRAIN;
                        waitCnt <= drainCycles(phase[0] ? rlat : wlat);
                    end
                end
                MSTS_DRAIN: begin
                    // Late fails of the last reads still stall the controller
                    if (rxBus[RX_STALL]) begin
                        state <= MSTS_LOG;
                        seenLog <= 1'b0;
                        fromDrain <= 1'b1;
                    end else if (waitCnt != '0) begin
                        waitCnt <= waitCnt - 4'h1;
                    end else if (lastPhase) begin
                        state <= MSTS_DONE;
                    end else begin
                        phase <= phase + 2'h1;
                        state <= MSTS_START;
                    end
                end
                MSTS_LOG: begin
                    // Hold until the tester has shifted the log out
                    if (logShift) begin
                        seenLog <= 1'b1;
                    end else if (seenLog) begin
                        state <= fromDrain ? MSTS_DRAIN : MSTS_ACCESS;
                    end
                end
                MSTS_DONE: begin
                    if (!runReq) begin
                        state <= MSTS_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            firstAcc <= 1'b0;
        end else begin
            firstAcc <= (state == MSTS_START);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Command bus to the dispatch unit
    always_comb begin
        txBus = '0;
        txBus[TX_STALL] = (state == MSTS_LOG);
        txBus[TX_SEED] = (state == MSTS_START) && ctrlReg[C_GONOGO];
        txBus[TX_BITMAP] = ctrlReg[C_BITMAP];
        txBus[TX_ROWF] = ctrlReg[C_ROWF];
        // Inverted march pass runs the other way
        txBus[TX_DOWN] = ctrlReg[C_DOWN] ^ (ctrlReg[C_MARCH] & phase[1]);
        txBus[TX_READ] = acc && phase[0];
        txBus[TX_WRITE] = acc && !phase[0];
        txBus[TX_CKBD] = ctrlReg[C_CKBD];
        txBus[TX_INV] = instrShift ? ctrlReg[0] : phase[1];
        txBus[TX_SACR] = sacr;
        txBus[TX_STEP] = acc && !sacr;
        txBus[TX_ARST] = (state == MSTS_START);
    end

    ////////////////////////////////////////////////////////////////////
    // Dispatch unit
    msts_dispatch u_dispatch (
        .clock(clock),
        .rstn(rstn),
        .testMode(testMode),
        .shiftEn(instrShift && state == MSTS_IDLE),
        .logShift(logShift),
        .txBus(txBus),
        .ramRdataAll(ramRdataAll),
        .rxBus(rxBus),
        .logBits(logBits),
        .ramWdata(ramWdata),
        .ramAddr(ramAddr),
        .ramBitEnable(ramBitEnable),
        .ramChipEnable(ramChipEnable),
        .ramWriteEnable(ramWriteEnable)
    );

    ////////////////////////////////////////////////////////////////////
    // Result bus to the tester
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            resultBus <= '0;
        end else begin
            if (logShift) begin
                resultBus[RES_W-1:2] <= logBits;
            end else begin
                resultBus[RES_W-1:2] <= rxBus[RX_W-1:RX_EXP];
            end
            resultBus[1] <= rxBus[RX_FAIL];
            resultBus[0] <= (state == MSTS_DONE);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    sequence logEntered;
        state == MSTS_LOG && !logShift;
    endsequence

    sequence logHeld;
        state == MSTS_LOG && logShift;
    endsequence

    log_stall_a: assert property (@(posedge clock) disable iff (!rstn)
        logHeld |=> state == MSTS_LOG)
        else $error("controller left stall during log shift");

    log_resume_a: assert property (@(posedge clock) disable iff (!rstn)
        logHeld ##1 logEntered |-> ##1 (state == MSTS_ACCESS || state == MSTS_DRAIN) || !testMode)
        else $error("controller did not resume after log shift");

    shift_pass_a: assert property (@(posedge clock) disable iff (!rstn)
        instrShift && state == MSTS_IDLE |=> ctrlReg[CTRL_W-1] == $past(serialIn))
        else $error("serial bit not captured");

    shift_fwd_a: assert property (@(posedge clock) disable iff (!rstn)
        instrShift |-> txBus[TX_INV] == ctrlReg[0])
        else $error("serial stream not forwarded");

    idle_reset_a: assert property (@(posedge clock) disable iff (!rstn)
        $rose(rstPipe[1]) |-> state == MSTS_IDLE && resultBus == '0)
        else $error("not idle after reset");

    mode_gate_a: assert property (@(posedge clock) disable iff (!rstn)
        !testMode |=> state == MSTS_IDLE [*2])
        else $error("state machine ran outside test mode");

    fail_flag_a: assert property (@(posedge clock) disable iff (!rstn)
        rxBus[RX_FAIL] |=> resultBus[1])
        else $error("fail flag not reported");

    done_flag_a: assert property (@(posedge clock) disable iff (!rstn)
        state == MSTS_DRAIN && waitCnt == '0 && lastPhase && testMode |=> ##1 resultBus[0])
        else $error("finished flag missing");

    result_log_a: assert property (@(posedge clock) disable iff (!rstn)
        logShift |=> resultBus[RES_W-1:2] == $past(logBits))
        else $error("log bits not on result bus");

    drain_len_a: assert property (@(posedge clock) disable iff (!rstn)
        state == MSTS_ACCESS ##1 state == MSTS_DRAIN |-> waitCnt >= WAIT_W'(RD_PIPE))
        else $error("drain shorter than read pipe");
endmodule // msts_sequencer

// >>> sim/msts_tester.sv
// Tester model driving the serial load, run and log pins
`timescale 1ns/1ps
module msts_tester
    import msts_pkg::*;
(
    input wire logic clock, // Core clock
    input wire logic [RES_W-1:0] resultBus, // Device results
    output logic testModeOn, // Test mode
    output logic instrShiftEn, // Load enable
    output logic logShiftEn, // Log shift enable
    output logic serialInstrIn, // Serial data
    output logic runEn, // Run enable
    output logic [63:0] shiftCap // Result bit 2 during a load
);
    initial begin
        testModeOn = 1'b0;
        instrShiftEn = 1'b0;
        logShiftEn = 1'b0;
        serialInstrIn = 1'b0;
        runEn = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic load(input logic [55:0] ins);
        for (int i = 0; i < 64; i++) begin
            instrShiftEn = i < 56;
            serialInstrIn = i < 56 ? ins[i] : ~ins[55];
            @(negedge clock);
            shiftCap[i] = resultBus[2];
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic runTest(input logic doLog, output logic done, output logic early);
        logic logged;
        logged = 1'b0;
        done = 1'b0;
        early = 1'b0;
        runEn = 1'b1;
        for (int n = 0; n < 8000 && !done; n++) begin
            @(negedge clock);
            if (doLog && resultBus[1] === 1'b1 && !logged) begin
                logShiftEn = 1'b1;
                for (int k = 0; k < 90; k++) begin
                    @(negedge clock);
                    early = early | resultBus[0];
                end
                logShiftEn = 1'b0;
                logged = 1'b1;
            end
            done = resultBus[0] === 1'b1;
        end
        runEn = 1'b0;
        repeat (6) @(negedge clock);
    endtask
endmodule // msts_tester

// >>> sim/msts_sequencer_tb.sv
// Self-checking bench for the memory self-test sequencer
`timescale 1ns/1ps
module msts_sequencer_tb;
    import msts_pkg::*;
    logic clock, resetn, testModeOn, instrShiftEn, logShiftEn, serialInstrIn, runEn;
    logic [RDATA_W-1:0] ramRdataAll;
    logic [RES_W-1:0] resultBus;
    logic [DATA_W-1:0] ramWdata, shiftCap, mem [0:2047];
    logic [ADDR_W-1:0] ramAddr;
    logic [BE_W-1:0] ramBitEnable;
    logic [CE_W-1:0] ramChipEnable;
    logic ramWriteEnable, faultOn, done, early, expFail, ok;
    logic [1:0] faultCpu;
    logic [3:0] cpuEn;
    logic [31:0] rnd, noise;
    logic [55:0] ins, cur;
    logic [2047:0] wrSeen, rdSeen;
    int failCount, checked, locs;
    msts_sequencer dut (.clock(clock), .resetn(resetn), .testModeOn(testModeOn),
        .instrShiftEn(instrShiftEn), .logShiftEn(logShiftEn), .serialInstrIn(serialInstrIn),
        .runEn(runEn), .ramRdataAll(ramRdataAll), .resultBus(resultBus), .ramWdata(ramWdata),
        .ramAddr(ramAddr), .ramBitEnable(ramBitEnable), .ramChipEnable(ramChipEnable),
        .ramWriteEnable(ramWriteEnable));
    msts_tester tester (.clock(clock), .resultBus(resultBus), .testModeOn(testModeOn),
        .instrShiftEn(instrShiftEn), .logShiftEn(logShiftEn), .serialInstrIn(serialInstrIn),
        .runEn(runEn), .shiftCap(shiftCap));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [55:0] mkInstr(input logic [3:0] m, input logic [3:0] en,
        input logic [3:0] mx, input logic my, input logic [3:0] seed, input logic [17:0] ce);
        logic [55:0] v;
        v = '0;
        v[DISP_W + (m[0] ? C_CKBD : C_MARCH)] = 1'b1;
        v[DISP_W + C_DOWN] = m[1];
        v[DISP_W + C_ROWF] = m[2];
        v[DISP_W + C_BITMAP] = m[3];
        v[D_CPU +: NCPU] = en;
        v[D_MAXX +: X_W] = mx;
        v[D_MAXY] = my;
        v[D_SEED +: SEED_W] = seed;
        v[D_CE +: CE_W] = ce;
        return v;
    endfunction
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        checked++;
        if (got !== exp) begin
            failCount++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic closeOut();
        if (failCount == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    always @(negedge clock) noise <= lfsr(noise ^ 32'h1);
    // RAM model: synchronous read, released bus shows a changing pattern
    always @(posedge clock) begin
        for (int c = 0; c < NCPU; c++) begin
            if (ramChipEnable == '0 || ramWriteEnable !== 1'b0) ramRdataAll[64*c +: 64] <= {noise, ~noise};
            else ramRdataAll[64*c +: 64] <= mem[ramAddr] ^ 64'(faultOn && faultCpu == c && ramAddr == '0);
        end
        if (ramChipEnable != '0) begin
            chk("chipEnable", 64'(cur[D_CE +: CE_W]), 64'(ramChipEnable));
            chk("bitEnable", 64'(BE_ALL), 64'(ramBitEnable));
            if (ramWriteEnable) mem[ramAddr] <= ramWdata;
            if (ramWriteEnable) wrSeen[ramAddr] <= 1'b1;
            else rdSeen[ramAddr] <= 1'b1;
        end
        if (resultBus[1]) faultOn <= 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        resetn = 1'b0;
        faultOn = 1'b0;
        faultCpu = 2'h0;
        noise = 32'h0;
        rnd = 32'h948cca3e;
        cur = '0;
        failCount = 0;
        checked = 0;
        for (int a = 0; a < 2048; a++) mem[a] = '0;
        repeat (20) @(negedge clock);
        resetn = 1'b1;
        tester.testModeOn = 1'b1;
        repeat (6) @(negedge clock);
        chk("result", '0, 64'(resultBus));
        chk("chipEnableIdle", '0, 64'(ramChipEnable));
        for (int t = 0; t < CE_W; t++) begin
            rnd = lfsr(rnd);
            cpuEn = t == 0 ? 4'hf : rnd[3:0];
            faultCpu = rnd[5:4];
            cpuEn[faultCpu] = cpuEn[faultCpu] | (t == CE_W - 1);
            ins = mkInstr(t == 0 ? 4'h0 : {t == CE_W - 1 || rnd[6], rnd[9:7]}, cpuEn,
                t == 0 ? 4'h3 : {2'h0, rnd[11:10]}, rnd[12], rnd[16:13], 18'h1 << t);
            ins[DISP_W + C_GONOGO] = rnd[18];
            tester.load(ins);
            ok = 1'b0;
            for (int o = 0; o < 13; o++) ok = ok | (shiftCap[o +: 48] === cur[47:0]);
            chk("shiftOut", 64'h1, 64'(ok));
            chk("failCleared", '0, 64'(resultBus[1]));
            cur = ins;
            wrSeen = '0;
            rdSeen = '0;
            if (t == CE_W - 2) begin
                tester.testModeOn = 1'b0;
                tester.runEn = 1'b1;
                repeat (100) @(negedge clock);
                chk("finishedOff", '0, 64'(resultBus[0]));
                chk("accessOff", '0, 64'($countones(wrSeen | rdSeen)));
                tester.runEn = 1'b0;
                tester.testModeOn = 1'b1;
                repeat (6) @(negedge clock);
            end
            faultOn = t != 0 && (rnd[17] || t == CE_W - 1);
            expFail = faultOn && cpuEn[faultCpu];
            tester.runTest(ins[DISP_W + C_BITMAP], done, early);
            chk("finished", 64'h1, 64'(done));
            if (!done) closeOut();
            chk("finishedLow", '0, 64'(resultBus[0]));
            chk("failFlag", 64'(expFail), 64'(resultBus[1]));
            chk("logStall", '0, 64'(early));
            locs = (int'(ins[D_MAXX +: X_W]) + 1) * (ins[D_MAXY] ? 16 : 8);
            chk("written", 64'(locs), 64'($countones(wrSeen)));
            chk("read", 64'(locs), 64'($countones(rdSeen)));
        end
        closeOut();
    end
endmodule // msts_sequencer_tb
